// File: pkg/cbscr_cfg.svh
/*
 * Constants of the socket clock and reset block: widths, counts,
 * reset values and pin levels.
 * Assumes it is included by the package and by the design file only.
 */
`ifndef CBSCR_CFG_SVH
`define CBSCR_CFG_SVH

// ==========================================================
// Widths
`define CBSCR_AD_W 32
`define CBSCR_CNT_W 4

// ==========================================================
// Counts, in host clock periods
`define CBSCR_ANNOUNCE_PERIODS 4'h2
`define CBSCR_WAIT_PERIODS 4'h4
`define CBSCR_SLOW_DIV 4'h4
`define CBSCR_CNT_ZERO 4'h0
`define CBSCR_CNT_ONE 4'h1

// ==========================================================
// Pin levels
`define CBSCR_LEVEL_LOW 1'b0
`define CBSCR_LEVEL_HIGH 1'b1
`define CBSCR_OE_DRIVE 1'b0
`define CBSCR_OE_RELEASE 1'b1
`define CBSCR_AD_IDLE 32'h0000_0000

`endif

// File: pkg/cbscr_pkg.sv
/*
 * Types of the socket clock and reset block: state enumeration,
 * the state records of both clock domains and the host carriers.
 * Assumes cbscr_cfg.svh is on the include path.
 */
`include "cbscr_cfg.svh"

package cbscr_pkg;

	// ==========================================================
	// Clock-run sequencer
	typedef enum logic [1:0] {
		CBSCR_RUN,
		CBSCR_ANNOUNCE,
		CBSCR_WAIT,
		CBSCR_LOW
	} cbscr_cr_state_type;

	// ==========================================================
	// Host side carriers
	typedef struct packed {
		logic slow;
		logic stop;
		logic card_reset;
	} cbscr_host_req_type;

	typedef struct packed {
		logic clock_full;
		logic card_in_reset;
	} cbscr_host_stat_type;

	// ==========================================================
	// State of the fast control domain
	typedef struct packed {
		logic pclk_s1;
		logic pclk_s2;
		logic pclk_s3;
		logic run_s1;
		logic run_s2;
		cbscr_host_req_type req_s1;
		cbscr_host_req_type req_s2;
		logic [`CBSCR_AD_W-1:0] ad_s1;
		logic [`CBSCR_AD_W-1:0] ad_s2;
		logic [`CBSCR_AD_W-1:0] ad_smp;
		logic [`CBSCR_AD_W-1:0] ad_out;
		logic ad_oe_n;
		logic cclk;
		logic crst_n;
		logic cr_out;
		logic cr_oe_n;
		logic clock_full;
		cbscr_cr_state_type state;
		logic [`CBSCR_CNT_W-1:0] cnt;
		logic [`CBSCR_CNT_W-1:0] div;
	} cbscr_core_type;

	// ==========================================================
	// State of the host clock domain
	typedef struct packed {
		cbscr_host_req_type req;
		cbscr_host_stat_type stat_s1;
		cbscr_host_stat_type stat_s2;
	} cbscr_host_type;

endpackage : cbscr_pkg

// File: design/cbscr_clock_reset.sv
/*
 * Socket clock and reset control for one card slot: makes the card
 * clock from the host bus clock, runs the clock-run handshake, drives
 * the card reset, and samples the shared address/data lines.
 * Assumes the host bus clock is slower than half of clk, the clock-run
 * line has a pull-up, and the host bench resolves the open pins.
 */
`timescale 1ns/100ps

module cbscr_clock_reset
	import cbscr_pkg::*;
(
	input wire logic clk, // Control clock, 200 MHz
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic pci_clk, // Host bus clock, card clock source
	input cbscr_host_req_type host_req, // Host requests, pci_clk domain
	output cbscr_host_stat_type host_stat, // Status, pci_clk domain
	output logic socket_card_clock, // Card clock pin
	output logic socket_card_reset_n, // Card reset pin, active low
	input wire logic socket_clock_run_request_in, // Clock-run pin level
	output logic socket_clock_run_request_out, // Clock-run drive value
	output logic socket_clock_run_request_oe_n, // Low while driving
	input wire logic [`CBSCR_AD_W-1:0] socket_addr_data_in, // Pin levels
	output logic [`CBSCR_AD_W-1:0] socket_addr_data_out, // Drive value
	output logic socket_addr_data_oe_n, // Low while driving
	output logic [`CBSCR_AD_W-1:0] card_ad_sample // Sampled at card clock rise
);

	`include "cbscr_cfg.svh"

	// ==========================================================
	// Host clock domain
	cbscr_host_type host_ff;
	cbscr_host_type nxt_host;
	cbscr_core_type core_ff;
	cbscr_core_type nxt_core;

	always_comb begin
		nxt_host = host_ff;
		// Registered so the crossing sees glitch-free levels
		nxt_host.req = host_req;
		nxt_host.stat_s1.clock_full = core_ff.clock_full;
		nxt_host.stat_s1.card_in_reset = ~core_ff.crst_n;
		nxt_host.stat_s2 = host_ff.stat_s1;
	end

	always_ff @(posedge pci_clk or negedge resetn) begin
		if (!resetn) begin
			host_ff <= '0;
		end else begin
			host_ff <= nxt_host;
		end
	end

	assign host_stat = host_ff.stat_s2;

	// ==========================================================
	// Control domain: edge events of the host bus clock
	logic pclk_rise;
	logic pclk_fall;
	logic want_low;
	logic card_asks;
	logic pulse;

	assign pclk_rise = core_ff.pclk_s2 & ~core_ff.pclk_s3;
	assign pclk_fall = ~core_ff.pclk_s2 & core_ff.pclk_s3;

	// Line low means the card holds its request
	assign card_asks = (core_ff.run_s2 == `CBSCR_LEVEL_LOW);

	// No slowdown while reset is held, so release always finds a clock edge
	assign want_low = (core_ff.req_s2.slow | core_ff.req_s2.stop)
		& core_ff.crst_n;

	// ==========================================================
	// Control domain: next state
	always_comb begin
		nxt_core = core_ff;
		pulse = 1'b0;

		nxt_core.pclk_s1 = pci_clk;
		nxt_core.pclk_s2 = core_ff.pclk_s1;
		nxt_core.pclk_s3 = core_ff.pclk_s2;
		nxt_core.run_s1 = socket_clock_run_request_in;
		nxt_core.run_s2 = core_ff.run_s1;
		nxt_core.req_s1 = host_ff.req;
		nxt_core.req_s2 = core_ff.req_s1;
		nxt_core.ad_s1 = socket_addr_data_in;
		nxt_core.ad_s2 = core_ff.ad_s1;

		if (pclk_rise) begin
			case (core_ff.state)
				CBSCR_RUN: begin
					pulse = 1'b1;
					nxt_core.cr_out = `CBSCR_LEVEL_LOW;
					nxt_core.cr_oe_n = `CBSCR_OE_DRIVE;
					if (want_low) begin
						// Drive the line high to warn the card
						nxt_core.state = CBSCR_ANNOUNCE;
						nxt_core.cnt = `CBSCR_ANNOUNCE_PERIODS;
						nxt_core.cr_out = `CBSCR_LEVEL_HIGH;
					end
				end
				CBSCR_ANNOUNCE: begin
					pulse = 1'b1;
					if (core_ff.cnt == `CBSCR_CNT_ONE) begin
						nxt_core.state = CBSCR_WAIT;
						nxt_core.cnt = `CBSCR_WAIT_PERIODS;
						nxt_core.cr_oe_n = `CBSCR_OE_RELEASE;
					end else begin
						nxt_core.cnt = core_ff.cnt - `CBSCR_CNT_ONE;
					end
				end
				CBSCR_WAIT: begin
					pulse = 1'b1;
					if (card_asks || !want_low) begin
						// Card or host keeps the clock: back to full rate
						nxt_core.state = CBSCR_RUN;
						nxt_core.cr_out = `CBSCR_LEVEL_LOW;
						nxt_core.cr_oe_n = `CBSCR_OE_DRIVE;
					end else if (core_ff.cnt == `CBSCR_CNT_ZERO) begin
						nxt_core.state = CBSCR_LOW;
						nxt_core.div = `CBSCR_CNT_ZERO;
						nxt_core.clock_full = 1'b0;
					end else begin
						nxt_core.cnt = core_ff.cnt - `CBSCR_CNT_ONE;
					end
				end
				CBSCR_LOW: begin
					// Stop gives no pulse while it holds; slow gives one in SLOW_DIV
					pulse = ~core_ff.req_s2.stop
						& (core_ff.div == `CBSCR_CNT_ZERO);
					if (core_ff.div == `CBSCR_SLOW_DIV - `CBSCR_CNT_ONE) begin
						nxt_core.div = `CBSCR_CNT_ZERO;
					end else begin
						nxt_core.div = core_ff.div + `CBSCR_CNT_ONE;
					end
					if (card_asks || !want_low) begin
						// Full rate from this very rise, even out of a stop
						pulse = 1'b1;
						nxt_core.state = CBSCR_RUN;
						nxt_core.clock_full = 1'b1;
						nxt_core.cr_out = `CBSCR_LEVEL_LOW;
						nxt_core.cr_oe_n = `CBSCR_OE_DRIVE;
					end
				end
				default: begin
					nxt_core.state = CBSCR_RUN;
					nxt_core.clock_full = 1'b1;
				end
			endcase

			// Rising card edge only on a host clock rise
			nxt_core.cclk = pulse;

			if (pulse) begin
				nxt_core.ad_smp = core_ff.ad_s2;
			end

			// Release lands on the card clock's rising edge
			if (pulse && !core_ff.req_s2.card_reset) begin
				nxt_core.crst_n = 1'b1;
			end
		end else if (pclk_fall) begin
			// A slowed or stopped clock rests low
			nxt_core.cclk = `CBSCR_LEVEL_LOW;
		end

		// Assertion does not wait for any card clock edge
		if (core_ff.req_s2.card_reset) begin
			nxt_core.crst_n = 1'b0;
		end

		// Hold the floated card lines at a valid level during reset
		nxt_core.ad_out = `CBSCR_AD_IDLE;
		nxt_core.ad_oe_n = nxt_core.crst_n ? `CBSCR_OE_RELEASE
			: `CBSCR_OE_DRIVE;
	end

	// ==========================================================
	// Control domain: state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_ff <= '0;
			core_ff.run_s1 <= `CBSCR_LEVEL_HIGH;
			core_ff.run_s2 <= `CBSCR_LEVEL_HIGH;
			core_ff.ad_out <= `CBSCR_AD_IDLE;
			core_ff.ad_oe_n <= `CBSCR_OE_DRIVE;
			core_ff.cclk <= `CBSCR_LEVEL_LOW;
			core_ff.crst_n <= 1'b0;
			core_ff.cr_out <= `CBSCR_LEVEL_LOW;
			core_ff.cr_oe_n <= `CBSCR_OE_DRIVE;
			core_ff.clock_full <= 1'b1;
			core_ff.state <= CBSCR_RUN;
		end else begin
			core_ff <= nxt_core;
		end
	end

	// ==========================================================
	// Pins
	assign socket_card_clock = core_ff.cclk;
	assign socket_card_reset_n = core_ff.crst_n;
	assign socket_clock_run_request_out = core_ff.cr_out;
	assign socket_clock_run_request_oe_n = core_ff.cr_oe_n;
	assign socket_addr_data_out = core_ff.ad_out;
	assign socket_addr_data_oe_n = core_ff.ad_oe_n;
	assign card_ad_sample = core_ff.ad_smp;

endmodule : cbscr_clock_reset

// File: tb/cbscr_sva.sv
/* Pin timing checker of the socket clock and reset block.
 Assumes it is bound to cbscr_clock_reset. */
`timescale 1ns/100ps
module cbscr_sva (
	input wire logic clk, // Control clock
	input wire logic resetn, // Reset, active low
	input wire logic pci_clk, // Host bus clock
	input wire logic socket_card_clock, // Card clock pin
	input wire logic socket_card_reset_n, // Card reset pin
	input wire logic socket_clock_run_request_in, // Clock-run level
	input wire logic socket_clock_run_request_out, // Clock-run drive
	input wire logic socket_clock_run_request_oe_n, // Clock-run enable
	input wire logic [31:0] socket_addr_data_in, // Pin levels
	input wire logic [31:0] socket_addr_data_out, // Drive value
	input wire logic socket_addr_data_oe_n, // Drive enable
	input wire logic [31:0] card_ad_sample // Captured word
);
	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_rel; $rose(socket_card_reset_n) |-> $rose(socket_card_clock); endproperty
	a_rel: assert property (p_rel) else $error("reset release off clock");
	property p_rise; $rose(socket_card_clock) |-> $past(pci_clk, 2); endproperty
	a_rise: assert property (p_rise) else $error("card clock rise");
	property p_fall; $fell(pci_clk) |-> ##[2:5] !socket_card_clock; endproperty
	a_fall: assert property (p_fall) else $error("card clock not low");
	property p_keep;
		!socket_clock_run_request_in [*8] ##1 $rose(pci_clk) |-> ##[1:6] $rose(socket_card_clock);
	endproperty
	a_keep: assert property (p_keep) else $error("clock not full");
	property p_ann;
		$rose(socket_clock_run_request_oe_n) |->
			$past(socket_clock_run_request_out) && $past(socket_clock_run_request_out, 20);
	endproperty
	a_ann: assert property (p_ann) else $error("no announce");
	property p_drv;
		!socket_card_reset_n && !$past(socket_card_reset_n) |->
			!socket_addr_data_oe_n && socket_addr_data_out == '0;
	endproperty
	a_drv: assert property (p_drv) else $error("lines not driven");
	property p_when;
		!$stable(card_ad_sample) |-> socket_card_clock && !$past(socket_card_clock, 2);
	endproperty
	a_when: assert property (p_when) else $error("sample off edge");
	property p_val;
		$stable(socket_addr_data_in) [*5] ##0 $rose(socket_card_clock) |->
			##[0:1] card_ad_sample == socket_addr_data_in;
	endproperty
	a_val: assert property (p_val) else $error("sample value");
	c_slow: cover property ($rose(socket_clock_run_request_oe_n));
	c_rel: cover property ($rose(socket_card_reset_n));
	c_keep: cover property (!socket_clock_run_request_in && socket_card_clock);
endmodule : cbscr_sva
bind cbscr_clock_reset cbscr_sva u_sva (.*);

// File: tb/cbscr_card.sv
/* Card model at the far side of the socket.
 Assumes the bench resolves the shared pins. */
`timescale 1ns/100ps
module cbscr_card (
	input wire logic cclk, // Card clock
	input wire logic rst_n, // Card reset, active low
	input wire logic want_fast, // Ask for full clock
	input wire logic [31:0] word, // Next word to drive
	output logic pull_low, // Clock-run pulled low
	output logic ad_en, // Driving address/data
	output logic [31:0] ad // Address/data drive
);
	// Launch on the fall so the word is settled at the rise
	always_ff @(negedge cclk or negedge rst_n) begin
		if (!rst_n) begin
			ad_en <= 1'b0;
			ad <= '0;
		end else begin
			ad_en <= 1'b1;
			ad <= word;
		end
	end
	assign pull_low = want_fast & rst_n;
endmodule : cbscr_card

// File: tb/tb.sv
/* Bench of the socket clock and reset block with a card model.
 Assumes design, checker and card files compile first. */
`timescale 1ns/100ps
module tb import cbscr_pkg::*;;
	logic clk = 0, resetn = 0, pci_clk = 0, want_fast = 0;
	cbscr_host_req_type host_req = '0;
	cbscr_host_stat_type host_stat;
	logic cclk, crst_n, cr_out, cr_oe_n, ad_oe_n, pull_low, ad_en, run;
	logic [31:0] ad_out, ad_in, card_ad, smp, word = '0;
	logic [31:0] q[$];
	int miscompares = 0, checked = 0, cyc = 0, rises = 0, seed = 47585, k;
	always #2.5 clk = ~clk;
	always #32 pci_clk = ~pci_clk;
	// Pull-up on clock-run; undriven data lines wander
	assign run = (cr_oe_n | cr_out) & ~pull_low;
	assign ad_in = !ad_oe_n ? ad_out : ad_en ? card_ad : ~card_ad;
	cbscr_clock_reset dut (.clk(clk), .resetn(resetn), .pci_clk(pci_clk),
		.host_req(host_req), .host_stat(host_stat), .socket_card_clock(cclk),
		.socket_card_reset_n(crst_n), .socket_clock_run_request_in(run),
		.socket_clock_run_request_out(cr_out), .socket_clock_run_request_oe_n(cr_oe_n),
		.socket_addr_data_in(ad_in), .socket_addr_data_out(ad_out),
		.socket_addr_data_oe_n(ad_oe_n), .card_ad_sample(smp));
	cbscr_card card (.cclk(cclk), .rst_n(crst_n), .want_fast(want_fast), .word(word),
		.pull_low(pull_low), .ad_en(ad_en), .ad(card_ad));
	// ==========================================================
	// Model and checks
	task chk(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task span(input int n);
		int r;
		r = rises;
		repeat (n) @(posedge pci_clk);
		k = rises - r;
	endtask : span
	task req(input logic [2:0] v, input int n);
		@(posedge pci_clk);
		#1 host_req = v;
		repeat (n) @(posedge pci_clk);
	endtask : req
	task give_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	always @(posedge cclk) rises++;
	always @(posedge cclk) if (ad_en) begin
		q.push_back(card_ad);
		repeat (3) @(posedge clk);
		chk(smp, q.pop_front());
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ==========================================================
	// Scenarios
	initial begin
		repeat (8) @(posedge clk);
		#1 resetn = 1;
		req(3'b001, 4);
		chk(crst_n, 0);
		chk(ad_oe_n, 0);
		chk(host_stat.card_in_reset, 1);
		req(3'b000, 4);
		chk(crst_n, 1);
		span(8);
		chk(k, 8);
		repeat (16) begin
			word = $random(seed);
			span(1);
		end
		$display("reset and full rate done");
		req(3'b100, 12);
		span(8);
		chk(k, 2);
		chk(host_stat.clock_full, 0);
		chk(cr_oe_n, 1);
		req(3'b010, 4);
		span(8);
		chk(k, 0);
		chk(cclk, 0);
		want_fast = 1;
		span(4);
		span(8);
		chk(k, 8);
		req(3'b100, 12);
		span(8);
		chk(k, 8);
		chk(host_stat.clock_full, 1);
		$display("slow, stop and clock run done");
		give_verdict();
	end
endmodule : tb
